// [rtl/dsl_axil_slave.sv]
/*
 * axi4-lite slave front end: one write and one read in flight.
 * assumes the register file answers decode combinationally.
 */
`timescale 1ns/1ns
`default_nettype none
module dsl_axil_slave
    import dsl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output dsl_wreq_t wreq,
    input wire logic wr_ok,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_full_r, w_full_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_hs, w_hs, ar_hs;

    assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
    assign s_axi_wready = !w_full_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign aw_hs = s_axi_awvalid && s_axi_awready;
    assign w_hs = s_axi_wvalid && s_axi_wready;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;
    assign wreq = '{en: aw_full_r && w_full_r && !s_axi_bvalid,
                    addr: aw_addr_r, data: w_data_r, strb: w_strb_r};

    // address and data taken in either order
    always_ff @(posedge ref_clk) begin
        if (sys_rst || wreq.en) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
        end else begin
            aw_full_r <= aw_full_r || aw_hs;
            w_full_r <= w_full_r || w_hs;
        end
        if (aw_hs) aw_addr_r <= s_axi_awaddr;
        if (w_hs) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
        end else begin
            if (wreq.en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_hs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : dsl_axil_slave
`default_nettype wire

// [rtl/dsl_lock_fsm.sv]
/*
 * security lock machine: freeze, set password, unlock, erase unit,
 * register file and password sector capture behind axi4-lite.
 * assumes nv_init is pulsed once when the password store is blank and
 * sys_rst is the power-on or hardware reset; both on ref_clk.
 */
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module dsl_lock_fsm
    import dsl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic nv_init,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic cmd_done_r,
    output logic cmd_abort_r,
    output logic erase_req_r,
    output logic wear_level_req_r,
    output logic frozen_r,
    output logic locked_r
);
    dsl_wreq_t wreq;
    logic wr_ok, rd_ok;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    dsl_state_t st_r, st_nxt;
    logic [7:0] op_r, drv_head_r, lba_high_r, lba_mid_r, lba_low_r;
    logic [7:0] sector_count_r, feature_r;
    logic [15:0] ctrl_r;
    logic [PW_WORDS-1:0][15:0] buf_r;
    logic [7:0] word_cnt_r;
    logic [2:0] tries_r;
    logic enabled_r, max_level_r, master_set_r, prep_r, err_r;
    logic sec_supported_r;
    logic umatch, mmatch;

    dsl_axil_slave u_bus (
        .ref_clk(ref_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .wreq(wreq), .wr_ok(wr_ok),
        .rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
    );

    // register decode
    wire wr_lane0 = wreq.en && wreq.strb[0];
    wire wr_cmd = wr_lane0 && wreq.addr == OFF_CMD;
    wire wr_data = wreq.en && wreq.addr == OFF_DATA;
    wire wr_ctl = wr_lane0 && wreq.addr == OFF_CONTROL;
    wire wr_sc = wr_lane0 && wreq.addr == OFF_SECT_CNT;
    assign wr_ok = wreq.addr <= OFF_CONTROL && wreq.addr[1:0] == 2'b00;
    assign rd_ok = rd_addr <= OFF_CONTROL && rd_addr[1:0] == 2'b00;

    wire [7:0] st_bits = {st_r != ST_IDLE, 3'h0, st_r == ST_DATA, 2'h0,
                          err_r};
    wire dsl_sec_t sec = '{tries: tries_r, master_set: master_set_r,
                           max_level: max_level_r, enabled: enabled_r,
                           locked: locked_r, frozen: frozen_r};
    assign rd_data =
        !rd_ok ? 32'h0000_0000 :
        rd_addr == OFF_DRV_HEAD ? {24'h00_0000, drv_head_r} :
        rd_addr == OFF_LBA_HIGH ? {24'h00_0000, lba_high_r} :
        rd_addr == OFF_LBA_MID ? {24'h00_0000, lba_mid_r} :
        rd_addr == OFF_LBA_LOW ? {24'h00_0000, lba_low_r} :
        rd_addr == OFF_SECT_CNT ? {24'h00_0000, sector_count_r} :
        rd_addr == OFF_STATUS ? {24'h00_0000, st_bits} :
        rd_addr == OFF_SEC_STATE ? {24'h00_0000, sec} :
        rd_addr == OFF_CONTROL ? {31'h0000_0000, sec_supported_r} :
        32'h0000_0000;

    // command start and early checks; lba, count, features unused
    wire [7:0] opc = wreq.data[7:0];
    wire cmd_start = wr_cmd && st_r == ST_IDLE;
    wire is_lock_cmd = opc == OP_SET_PW || opc == OP_UNLOCK ||
                       opc == OP_DIS_PW || opc == OP_ERASE_UNIT;
    wire known_op = opc == OP_SET_PW || opc == OP_UNLOCK ||
                    opc == OP_ERASE_PREP || opc == OP_ERASE_UNIT ||
                    opc == OP_FREEZE;
    wire frozen_rej = frozen_r && is_lock_cmd;
    wire tries_rej = tries_r == 3'h0 &&
                     (opc == OP_UNLOCK || opc == OP_ERASE_UNIT);
    wire prep_rej = opc == OP_ERASE_UNIT && !prep_r;
    wire is_wear = opc == OP_FREEZE && !sec_supported_r;
    wire early_abort = !is_wear && (!known_op || !sec_supported_r ||
                                    frozen_rej || tries_rej || prep_rej);
    wire needs_data = opc == OP_SET_PW || opc == OP_UNLOCK ||
                      opc == OP_ERASE_UNIT;
    wire start_data = cmd_start && !early_abort && needs_data;
    wire start_freeze = cmd_start && !early_abort && opc == OP_FREEZE &&
                        sec_supported_r;
    wire start_quick = cmd_start && !early_abort && !needs_data;

    // sector fields
    wire id_master = ctrl_r[CTRL_ID_BIT];
    wire lvl_max = ctrl_r[CTRL_LVL_BIT];
    wire exec = st_r == ST_EXEC;
    wire x_setpw = exec && op_r == OP_SET_PW;
    wire x_unlock = exec && op_r == OP_UNLOCK;
    wire x_erase = exec && op_r == OP_ERASE_UNIT;
    wire pw_match = id_master ? mmatch : umatch;
    wire unlock_rej = x_unlock && id_master && max_level_r;
    wire unlock_ok = x_unlock && !unlock_rej && pw_match;
    wire unlock_fail = x_unlock && !unlock_rej && !pw_match;
    wire erase_ok = x_erase && pw_match;
    wire erase_fail = x_erase && !pw_match;
    wire load_user = x_setpw && !id_master;
    wire load_master = x_setpw && id_master;
    wire abort_now = (cmd_start && early_abort) || unlock_rej ||
                     unlock_fail || erase_fail;
    wire done_now = (start_quick && !needs_data) || x_setpw ||
                    unlock_ok || erase_ok;

    dsl_pw_bank #(.W(PW_BITS)) u_user_pw (
        .ref_clk(ref_clk), .nv_init(nv_init), .load(load_user),
        .din(buf_r), .match(umatch)
    );
    dsl_pw_bank #(.W(PW_BITS)) u_master_pw (
        .ref_clk(ref_clk), .nv_init(nv_init), .load(load_master),
        .din(buf_r), .match(mmatch)
    );

    // state sequencing
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (start_data) st_nxt = ST_DATA;
            end
            ST_DATA: begin
                if (wr_data && word_cnt_r == LAST_WORD) st_nxt = ST_EXEC;
            end
            ST_EXEC: st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= ST_IDLE;
            word_cnt_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            if (start_data) word_cnt_r <= 8'h00;
            else if (wr_data && st_r == ST_DATA)
                word_cnt_r <= word_cnt_r + 8'h01;
        end
    end

    // password sector capture, words past 16 dropped
    wire [3:0] pw_idx = 4'(word_cnt_r - 8'h01);
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            op_r <= REG8_RST;
            ctrl_r <= 16'h0000;
        end else begin
            if (cmd_start) op_r <= opc;
            if (wr_data && st_r == ST_DATA) begin
                if (word_cnt_r == 8'h00) ctrl_r <= wreq.data[15:0];
                else if (word_cnt_r <= LAST_PW_WORD)
                    buf_r[pw_idx] <= wreq.data[15:0];
            end
        end
    end

    // task file registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            drv_head_r <= REG8_RST;
            lba_high_r <= REG8_RST;
            lba_mid_r <= REG8_RST;
            lba_low_r <= REG8_RST;
            sector_count_r <= REG8_RST;
            feature_r <= REG8_RST;
            sec_supported_r <= CTL_SUPPORT_RST;
        end else begin
            if (wr_lane0 && wreq.addr == OFF_DRV_HEAD)
                drv_head_r <= wreq.data[7:0];
            if (wr_lane0 && wreq.addr == OFF_LBA_HIGH)
                lba_high_r <= wreq.data[7:0];
            if (wr_lane0 && wreq.addr == OFF_LBA_MID)
                lba_mid_r <= wreq.data[7:0];
            if (wr_lane0 && wreq.addr == OFF_LBA_LOW)
                lba_low_r <= wreq.data[7:0];
            if (wr_lane0 && wreq.addr == OFF_FEATURE)
                feature_r <= wreq.data[7:0];
            if (start_freeze) sector_count_r <= 8'h00;
            else if (wr_sc) sector_count_r <= wreq.data[7:0];
            if (wr_ctl) sec_supported_r <= wreq.data[CTL_SUPPORT_BIT];
        end
    end

    // security state held across hardware reset
    always_ff @(posedge ref_clk) begin
        if (nv_init) begin
            enabled_r <= 1'b0;
            max_level_r <= 1'b0;
            master_set_r <= 1'b0;
        end else begin
            if (load_user) begin
                enabled_r <= 1'b1;
                max_level_r <= lvl_max;
            end else if (erase_ok) begin
                enabled_r <= 1'b0;
                max_level_r <= 1'b0;
            end
            if (load_master) master_set_r <= 1'b1;
        end
    end

    // frozen, lock, tries and prepare
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            frozen_r <= 1'b0;
            tries_r <= UNLOCK_TRIES;
            locked_r <= enabled_r;
            prep_r <= 1'b0;
        end else begin
            if (start_freeze) frozen_r <= 1'b1;
            if (unlock_fail && locked_r && tries_r != 3'h0)
                tries_r <= tries_r - 3'h1;
            if (unlock_ok || erase_ok) locked_r <= 1'b0;
            if (cmd_start)
                prep_r <= opc == OP_ERASE_PREP && !early_abort;
        end
    end

    // completion strobes and error status
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cmd_done_r <= 1'b0;
            cmd_abort_r <= 1'b0;
            erase_req_r <= 1'b0;
            wear_level_req_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            cmd_done_r <= done_now;
            cmd_abort_r <= abort_now;
            erase_req_r <= erase_ok;
            wear_level_req_r <= cmd_start && is_wear;
            if (abort_now) err_r <= 1'b1;
            else if (cmd_start) err_r <= 1'b0;
        end
    end

    // reset delayed one edge, masks checks across the release edge
    logic rst_d_r;
    always_ff @(posedge ref_clk) begin
        rst_d_r <= sys_rst;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst || rst_d_r);

    a_freeze_enters:
        assert property (cmd_start && opc == OP_FREEZE && sec_supported_r
                         |=> frozen_r && cmd_done_r && !cmd_abort_r)
        else $error("freeze did not complete into frozen state");
    a_frozen_stays:
        assert property (frozen_r |=> frozen_r)
        else $error("frozen state left without reset");
    a_refreeze_done:
        assert property (frozen_r && cmd_start && opc == OP_FREEZE
                         && sec_supported_r |=> cmd_done_r && frozen_r)
        else $error("second freeze not completed");
    a_freeze_count:
        assert property (start_freeze |=> sector_count_r == 8'h00)
        else $error("sector count not zero after freeze");
    a_frozen_reject:
        assert property (frozen_r && cmd_start && is_lock_cmd
                         |=> cmd_abort_r && st_r == ST_IDLE)
        else $error("lock command accepted while frozen");
    a_wear_level:
        assert property (cmd_start && opc == OP_FREEZE && !sec_supported_r
                         |=> wear_level_req_r && $stable(frozen_r))
        else $error("freeze not handled as wear level");
    a_prep_needed:
        assert property (cmd_start && opc == OP_ERASE_UNIT && !prep_r
                         |=> cmd_abort_r)
        else $error("erase without prepare not aborted");
    a_erase_mismatch:
        assert property (x_erase && !pw_match
                         |=> cmd_abort_r && !erase_req_r)
        else $error("erase with bad password not aborted");
    a_tries_dec:
        assert property (unlock_fail && locked_r && tries_r != 3'h0
                         |=> tries_r == $past(tries_r) - 3'h1 && cmd_abort_r)
        else $error("failed unlock did not decrement tries");
    a_tries_zero:
        assert property (tries_r == 3'h0 && cmd_start && opc == OP_UNLOCK
                         |=> cmd_abort_r ##1 tries_r == 3'h0)
        else $error("unlock accepted with no tries left");
    a_unlocked_tries:
        assert property (x_unlock && !locked_r |=> $stable(tries_r))
        else $error("tries changed while unlocked");
    a_master_max:
        assert property (x_unlock && id_master && max_level_r
                         |=> cmd_abort_r && $stable(locked_r)
                         && $stable(tries_r))
        else $error("master unlock at maximum level not rejected");
    a_master_keeps:
        assert property (load_master |=> $stable(enabled_r)
                         && $stable(max_level_r) && $stable(locked_r))
        else $error("master set changed lock state");
    a_reject_keeps:
        assert property (abort_now |=> $stable(enabled_r)
                         && $stable(max_level_r) && $stable(locked_r))
        else $error("rejected command changed security state");

    c_freeze: cover property (start_freeze ##1 cmd_done_r);
    c_unlock_ok: cover property (unlock_ok && locked_r);
    c_erase_ok: cover property (erase_ok);
    c_tries_out: cover property (tries_r == 3'h0);
endmodule : dsl_lock_fsm
`default_nettype wire

// [rtl/dsl_pw_bank.sv]
/*
 * one stored password with load and equality compare.
 * assumes nv_init stands for the non-volatile store being blank.
 */
`timescale 1ns/1ns
`default_nettype none
module dsl_pw_bank
    import dsl_pkg::*;
#(
    parameter int W = PW_BITS
) (
    input wire logic ref_clk,
    input wire logic nv_init,
    input wire logic load,
    input wire logic [W-1:0] din,
    output logic match
);
    logic [W-1:0] pw_r;

    // stored value, kept across sys_rst
    always_ff @(posedge ref_clk) begin
        if (nv_init) begin
            pw_r <= '0;
        end else if (load) begin
            pw_r <= din;
        end
    end

    assign match = (pw_r == din);
endmodule : dsl_pw_bank
`default_nettype wire

// [shared/dsl_pkg.sv]
/*
 * package for the drive security lock block: register offsets, opcodes,
 * field positions, reset values, bus carriers and machine states.
 * assumes a 32-bit axi4-lite register bus with byte addresses.
 */
package dsl_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DRV_HEAD = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_LBA_HIGH = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_LBA_MID = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_LBA_LOW = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SECT_CNT = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_FEATURE = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_DATA = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_SEC_STATE = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h28;
    localparam logic [7:0] OP_SET_PW = 8'hf1;
    localparam logic [7:0] OP_UNLOCK = 8'hf2;
    localparam logic [7:0] OP_ERASE_PREP = 8'hf3;
    localparam logic [7:0] OP_ERASE_UNIT = 8'hf4;
    localparam logic [7:0] OP_FREEZE = 8'hf5;
    localparam logic [7:0] OP_DIS_PW = 8'hf6;
    localparam logic [2:0] UNLOCK_TRIES = 3'h5;
    localparam int SECTOR_WORDS = 256;
    localparam int PW_WORDS = 16;
    localparam int PW_BITS = PW_WORDS * 16;
    localparam logic [7:0] LAST_WORD = 8'(SECTOR_WORDS - 1);
    localparam logic [7:0] LAST_PW_WORD = 8'(PW_WORDS);
    localparam int CTRL_ID_BIT = 0;
    localparam int CTRL_LVL_BIT = 8;
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_DRQ_BIT = 3;
    localparam int STAT_BSY_BIT = 7;
    localparam int CTL_SUPPORT_BIT = 0;
    localparam logic CTL_SUPPORT_RST = 1'b1;
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } dsl_wreq_t;

    typedef struct packed {
        logic [2:0] tries;
        logic master_set;
        logic max_level;
        logic enabled;
        logic locked;
        logic frozen;
    } dsl_sec_t;

    typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_EXEC} dsl_state_t;
endpackage : dsl_pkg

// [test/dsl_host_model.sv]
/* host controller model: axi4-lite master, one beat per task.
   assumes the slave answers in any number of cycles. */
`timescale 1ns/1ns
`default_nettype none
module dsl_host_model
    import dsl_pkg::*;
(
    input wire logic ref_clk,
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    assign s_axi_bready = 1'b1;
    assign s_axi_rready = 1'b1;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_wstrb, s_axi_araddr, s_axi_arvalid} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end while (!s_axi_bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
endmodule : dsl_host_model
`default_nettype wire

// [test/dsl_lock_fsm_tb_top.sv]
/* bench: security commands through the host model.
   assumes the host model is the only bus master. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    n_fail++; $display("Error %s exp %h got %h", n, e, s); end end
module dsl_lock_fsm_tb_top;
    import dsl_pkg::*;
    logic ref_clk = 0, sys_rst = 1, nv_init = 1;
    wire logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    wire logic [31:0] s_axi_wdata, s_axi_rdata;
    wire logic [3:0] s_axi_wstrb;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    wire logic s_axi_rvalid, s_axi_rready, cmd_done_r, cmd_abort_r;
    wire logic erase_req_r, wear_level_req_r, frozen_r, locked_r;
    int n_fail = 0, cmp_count = 0, n_dn = 0, n_ab = 0, n_er = 0, n_wl = 0;
    logic [31:0] rv;
    logic [1:0] rr;
    dsl_lock_fsm u_dut (.*);
    dsl_host_model u_host (.*);
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        n_dn <= n_dn + int'(cmd_done_r);
        n_ab <= n_ab + int'(cmd_abort_r);
        n_er <= n_er + int'(erase_req_r);
        n_wl <= n_wl + int'(wear_level_req_r);
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    task automatic rst;
        @(posedge ref_clk) sys_rst <= 1'b1;
        @(posedge ref_clk) sys_rst <= 1'b0;
        @(posedge ref_clk);
    endtask : rst
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        u_host.rd(a, rv, rr);
        `CHK("rdata", e, rv)
    endtask : chk_rd
    // command, optional sector, then done or abort expected
    task automatic go(input logic [7:0] op, input logic dat,
                      input logic [15:0] w0, pw, input logic ab);
        int s;
        int sa;
        s = n_dn + n_ab;
        sa = n_ab;
        u_host.wr(OFF_CMD, {24'h0, op});
        if (dat) for (int i = 0; i < SECTOR_WORDS; i++)
            u_host.wr(OFF_DATA, {16'h0, (i == 0) ? w0 : (i <= PW_WORDS) ?
                pw : 16'h0});
        for (int k = 0; k < 20 && n_dn + n_ab == s; k++) @(posedge ref_clk);
        `CHK("result", {1'b1, ab}, {n_dn + n_ab != s, n_ab != sa})
    endtask : go
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_fail++;
        test_done;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        nv_init <= 1'b0;
        chk_rd(OFF_SEC_STATE, 32'ha0);
        u_host.rd(8'h2c, rv, rr);
        `CHK("rresp", RESP_DECERR, rr)
        u_host.wr(8'h2c, 32'h0);
        `CHK("bresp", RESP_DECERR, s_axi_bresp)
        go(OP_ERASE_UNIT, 0, 0, 0, 1);
        go(OP_SET_PW, 1, 16'h0000, 16'h1234, 0);
        rst;
        `CHK("locked", 1'b1, locked_r)
        go(OP_UNLOCK, 1, 0, 16'h0bad, 1);
        chk_rd(OFF_SEC_STATE, 32'h86);
        go(OP_UNLOCK, 1, 16'h0001, 16'h0000, 0);
        `CHK("locked", 1'b0, locked_r)
        go(OP_UNLOCK, 1, 0, 16'h0bad, 1);
        chk_rd(OFF_SEC_STATE, 32'h84);
        go(OP_ERASE_PREP, 0, 0, 0, 0);
        go(OP_ERASE_UNIT, 1, 0, 16'h0bad, 1);
        go(OP_ERASE_PREP, 0, 0, 0, 0);
        go(OP_ERASE_UNIT, 1, 0, 16'h1234, 0);
        `CHK("erase", 1, n_er)
        go(OP_SET_PW, 1, 16'h0100, 16'h5555, 0);
        rst;
        go(OP_UNLOCK, 1, 16'h0001, 0, 1);
        chk_rd(OFF_SEC_STATE, 32'hae);
        go(OP_SET_PW, 1, 16'h0001, 16'h7777, 0);
        chk_rd(OFF_SEC_STATE, 32'hbe);
        for (int i = 0; i < 5; i++) go(OP_UNLOCK, 1, 0, 0, 1);
        go(OP_UNLOCK, 0, 0, 0, 1);
        go(OP_ERASE_PREP, 0, 0, 0, 0);
        go(OP_ERASE_UNIT, 0, 0, 0, 1);
        chk_rd(OFF_SEC_STATE, 32'h1e);
        rst;
        chk_rd(OFF_SEC_STATE, 32'hbe);
        go(OP_UNLOCK, 1, 0, 16'h5555, 0);
        u_host.wr(OFF_SECT_CNT, 32'h33);
        `CHK("bresp", RESP_OKAY, s_axi_bresp)
        go(OP_FREEZE, 0, 0, 0, 0);
        chk_rd(OFF_SECT_CNT, 32'h0);
        go(OP_FREEZE, 0, 0, 0, 0);
        `CHK("frozen", 1'b1, frozen_r)
        go(OP_SET_PW, 0, 0, 0, 1);
        go(OP_UNLOCK, 0, 0, 0, 1);
        go(OP_ERASE_UNIT, 0, 0, 0, 1);
        go(OP_DIS_PW, 0, 0, 0, 1);
        chk_rd(OFF_SEC_STATE, 32'hbd);
        rst;
        `CHK("frozen", 1'b0, frozen_r)
        u_host.wr(OFF_CONTROL, 32'h0);
        u_host.wr(OFF_CMD, {24'h0, OP_FREEZE});
        repeat (4) @(posedge ref_clk);
        `CHK("wear", 1, n_wl)
        `CHK("frozen", 1'b0, frozen_r)
        test_done;
    end
endmodule : dsl_lock_fsm_tb_top
`default_nettype wire
